//--- core/wiper_delay.sv
/*
 Loadable down-counter used for every pin timing wait.
 Assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
module wiper_delay
	import wiper_host_pkg::*;
(
	input  wire logic   clk,      // System clock
	input  wire logic   rst,      // Synchronous reset
	input  wire logic   load,     // Start a new wait
	input  wire count_t cycles,   // Wait length in cycles
	output logic        done      // Wait has elapsed
);
	count_t remain;
	count_t next_remain;

	always_comb begin
		next_remain = remain;
		if (load) begin
			next_remain = cycles;
		end else if (remain != 24'h000000) begin
			next_remain = remain - 24'h000001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			remain <= 24'h000000;
		end else begin
			remain <= next_remain;
		end
	end

	// Depends on the count only; a term in load would close a loop through the caller
	assign done = (remain == 24'h000000);
endmodule : wiper_delay

//--- core/wiper_host.sv
/*
 Host controller for a 32-position up/down nonvolatile potentiometer. Drives
 select, step strobe and direction pins; tracks the position it has set.
 Assumes a 100 MHz clock and a synchronous reset that coincides with the
 potentiometer's power-up.
*/
// How it works
// - Session opens with select falling, held low
// - Direction settles before each falling step
// - Repeat steps, leave strobe low after last
// - Strobe high before select rise stores
// - Strobe high 500 ns before select rise
`timescale 1ns/1ps
`include "wiper_host_params.svh"
module wiper_host
	import wiper_host_pkg::*;
#(
	parameter int PIN_ACT_CYC = `PIN_ACT_DELAY_CYC,  // Power-up pin wait
	parameter int STORE_CYC   = `STORE_TIME_CYC      // Nonvolatile write wait
)(
	input  wire logic       CLK,          // System clock
	input  wire logic       SYS_RST,      // Synchronous reset, power-up
	input  wire logic       CMD_VALID,    // Command request
	output logic            CMD_READY,    // Command accepted this cycle
	input  wire logic [4:0] CMD_TARGET,   // Target wiper position
	input  wire logic       CMD_STORE,    // Store after move
	input  wire logic       CMD_SAVE_ONLY,// Store current without moving
	input  wire logic [4:0] KNOWN_POS,    // Position read back from storage
	output logic            BUSY,         // Sequence in progress
	output logic [4:0]      POSITION,     // Position the host believes set
	output logic [4:0]      STORED_POS,   // Last position committed
	output logic            SEL_N,        // Select pin, active low
	output logic            STEP_N,       // Step strobe pin, active low
	output logic            DIR_UP        // Direction pin, high is up
);
	host_state_e state;
	host_state_e next_state;
	pos_t   pos, next_pos, target, next_target, stored, next_stored;
	logic   do_store, next_do_store, save_only, next_save_only;
	logic   sel_n, next_sel_n, step_n, next_step_n, dir, next_dir;
	logic   load;
	count_t wait_cyc;
	logic   done;
	logic   first;

	wiper_delay timer (
		.clk    (CLK),
		.rst    (SYS_RST),
		.load   (load),
		.cycles (wait_cyc),
		.done   (done)
	);

	assign CMD_READY = (state == ST_IDLE);

	always_comb begin
		next_state     = state;
		next_pos       = pos;
		next_target    = target;
		next_stored    = stored;
		next_do_store  = do_store;
		next_save_only = save_only;
		next_sel_n     = sel_n;
		next_step_n    = step_n;
		next_dir       = dir;
		load           = 1'b0;
		wait_cyc       = 24'h000000;
		case (state)
			ST_POWERUP: begin
				if (first) begin
					load     = 1'b1;
					wait_cyc = 24'(PIN_ACT_CYC);
				end else if (done) begin
					next_pos    = KNOWN_POS;
					next_stored = KNOWN_POS;
					next_state  = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// Nothing to move or store: a bare select pulse with strobe high would write
				if (CMD_VALID && (CMD_SAVE_ONLY || CMD_STORE || CMD_TARGET != pos)) begin
					next_target    = CMD_TARGET;
					next_do_store  = CMD_STORE;
					next_save_only = CMD_SAVE_ONLY;
					next_sel_n     = 1'b0;
					load           = 1'b1;
					if (CMD_SAVE_ONLY) begin
						wait_cyc   = 24'(`STORE_PULSE_CYC);
						next_state = ST_PULSE_LOW;
					end else begin
						wait_cyc   = 24'(`SEL_TO_STEP_CYC);
						next_state = ST_SELECT;
					end
				end
			end
			ST_SELECT: begin
				if (done) begin
					next_state = ST_END_CHOOSE;
					if (target != pos) begin
						next_dir   = (target > pos);
						load       = 1'b1;
						wait_cyc   = 24'(`DIR_SETUP_CYC);
						next_state = ST_DIR_SETUP;
					end
				end
			end
			ST_DIR_SETUP: begin
				if (done) begin
					next_step_n = 1'b0;
					if (dir && pos != `POS_MAX) begin
						next_pos = pos + 5'h01;
					end else if (!dir && pos != `POS_MIN) begin
						next_pos = pos - 5'h01;
					end
					load       = 1'b1;
					wait_cyc   = 24'(`STEP_LOW_CYC);
					next_state = ST_STEP_LOW;
				end
			end
			ST_STEP_LOW: begin
				if (done) begin
					if (pos == target) begin
						next_state = ST_END_CHOOSE;
					end else begin
						next_step_n = 1'b1;
						load        = 1'b1;
						wait_cyc    = 24'(`STEP_HIGH_CYC);
						next_state  = ST_STEP_HIGH;
					end
				end
			end
			ST_STEP_HIGH: begin
				if (done) begin
					next_step_n = 1'b0;
					if (dir && pos != `POS_MAX) begin
						next_pos = pos + 5'h01;
					end else if (!dir && pos != `POS_MIN) begin
						next_pos = pos - 5'h01;
					end
					load       = 1'b1;
					wait_cyc   = 24'(`STEP_LOW_CYC);
					next_state = ST_STEP_LOW;
				end
			end
			ST_END_CHOOSE: begin
				load = 1'b1;
				if (do_store) begin
					next_step_n = 1'b1;
					wait_cyc    = 24'(`STROBE_DESEL_CYC);
					next_state  = ST_STROBE_HOLD;
				end else begin
					next_sel_n = 1'b1;
					wait_cyc   = 24'(`STEP_LOW_DESEL_CYC);
					next_state = ST_ABORT_DESEL;
				end
			end
			ST_STROBE_HOLD: begin
				if (done) begin
					next_sel_n  = 1'b1;
					next_stored = pos;
					load        = 1'b1;
					wait_cyc    = 24'(STORE_CYC);
					next_state  = ST_STORE_WAIT;
				end
			end
			ST_ABORT_DESEL: begin
				// Strobe rises only after select is high, so nothing is stored
				if (done) begin
					next_step_n = 1'b1;
					load        = 1'b1;
					// Long gap so a following select pulse sees the strobe settled high
					wait_cyc    = 24'(`STROBE_DESEL_CYC);
					next_state  = ST_DESEL_GAP;
				end
			end
			ST_PULSE_LOW: begin
				if (done) begin
					next_sel_n  = 1'b1;
					next_stored = pos;
					load        = 1'b1;
					wait_cyc    = 24'(STORE_CYC);
					next_state  = ST_STORE_WAIT;
				end
			end
			ST_STORE_WAIT: begin
				if (done) begin
					next_state = ST_IDLE;
				end
			end
			ST_DESEL_GAP: begin
				if (done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state     <= ST_POWERUP;
			pos       <= 5'h00;
			target    <= 5'h00;
			stored    <= 5'h00;
			do_store  <= 1'b0;
			save_only <= 1'b0;
			sel_n     <= 1'b1;
			step_n    <= 1'b1;
			dir       <= 1'b0;
		end else begin
			state     <= next_state;
			pos       <= next_pos;
			target    <= next_target;
			stored    <= next_stored;
			do_store  <= next_do_store;
			save_only <= next_save_only;
			sel_n     <= next_sel_n;
			step_n    <= next_step_n;
			dir       <= next_dir;
		end
	end

	// Power-up wait must be loaded once at the first cycle after reset
	always_ff @(posedge CLK) begin
		first <= SYS_RST;
	end

	// Strobe-high run length, saturating, for the store hold check
	logic [5:0] high_run;
	logic [5:0] next_high_run;
	always_comb begin
		next_high_run = step_n ? high_run + 6'(high_run != 6'h3F) : 6'h00;
	end
	always_ff @(posedge CLK) begin
		high_run <= SYS_RST ? 6'h00 : next_high_run;
	end

	assign BUSY       = (state != ST_IDLE);
	assign POSITION   = pos;
	assign STORED_POS = stored; // value trusted only while storage healthy
	assign SEL_N      = sel_n;
	assign STEP_N     = step_n;
	assign DIR_UP     = dir;

	step_only_low_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(step_n) |-> !sel_n)
		else $error("step fell with select high");
	dir_stable_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(step_n) |-> $stable(dir) && $past(dir, 10) == dir)
		else $error("direction moved at step edge");
	sat_top_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		($past(pos) == 5'h1F && $past(dir)) |-> pos == 5'h1F)
		else $error("position wrapped");
	pos_step_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		($fell(step_n) && dir && $past(pos) != 5'h1F) |-> pos == $past(pos) + 5'h01)
		else $error("increment missing");
	abort_order_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		(state == ST_ABORT_DESEL) |-> sel_n && !step_n)
		else $error("abort order wrong");
	store_order_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$rose(sel_n) |-> step_n == (state == ST_STORE_WAIT))
		else $error("store without strobe high");
	hold_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$rose(sel_n) && step_n |-> high_run >= 6'(`STROBE_DESEL_CYC))
		else $error("strobe high too short");
	quiet_store_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == ST_STORE_WAIT |-> sel_n && step_n)
		else $error("pins moved during store");
	powerup_quiet_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == ST_POWERUP |-> sel_n && step_n)
		else $error("pins moved before power-up");
	pulse_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == ST_PULSE_LOW |-> save_only && step_n && !sel_n && pos == $past(pos))
		else $error("save pulse moved strobe or wiper");
endmodule : wiper_host

//--- core/wiper_host_params.svh
/*
 Timing constants for the wiper host controller: printed times and derived
 cycle counts at a 100 MHz clock. Assumes inclusion by bare name.
*/
`ifndef WIPER_HOST_PARAMS_SVH
`define WIPER_HOST_PARAMS_SVH

`define CLK_PERIOD_NS          10
`define POS_MAX                5'h1F
`define POS_MIN                5'h00
`define SEL_TO_STEP_NS         50
`define DIR_SETUP_NS           100
`define STEP_LOW_NS            50
`define STEP_HIGH_NS           100
`define STROBE_DESEL_NS        500
`define STEP_LOW_DESEL_NS      50
`define DESEL_HIGH_NS          100
`define STORE_PULSE_NS         100
`define STORE_TIME_MS          10
`define PIN_ACT_DELAY_MS       2
`define POS_LOAD_TIME_US       500

`define SEL_TO_STEP_CYC        ((`SEL_TO_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIR_SETUP_CYC          ((`DIR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_LOW_CYC           ((`STEP_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_HIGH_CYC          ((`STEP_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_DESEL_CYC       ((`STROBE_DESEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_LOW_DESEL_CYC     ((`STEP_LOW_DESEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DESEL_HIGH_CYC         ((`DESEL_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_PULSE_CYC        ((`STORE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_TIME_CYC         (`STORE_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define PIN_ACT_DELAY_CYC      (`PIN_ACT_DELAY_MS * 1000000 / `CLK_PERIOD_NS)

`endif

//--- core/wiper_host_pkg.sv
/*
 Types for the wiper host controller.
 Assumes the params header sits beside it.
*/
package wiper_host_pkg;
	typedef enum {
		ST_POWERUP,
		ST_IDLE,
		ST_SELECT,
		ST_DIR_SETUP,
		ST_STEP_LOW,
		ST_STEP_HIGH,
		ST_END_CHOOSE,
		ST_STROBE_HOLD,
		ST_ABORT_DESEL,
		ST_PULSE_LOW,
		ST_STORE_WAIT,
		ST_DESEL_GAP
	} host_state_e;

	typedef logic [23:0] count_t;
	typedef logic [4:0]  pos_t;
endpackage : wiper_host_pkg

//--- sim/pot_model.sv
/*
 Behavioural model of the 32-position up/down potentiometer driven by the host.
 Assumes power_on rises as the host leaves reset; delays are in ns.
*/
`timescale 1ns/1ps
module pot_model #(
	parameter int       PU_NS    = 200,   // Pin activation delay
	parameter int       STORE_NS = 300,   // Nonvolatile write time
	parameter bit [4:0] INIT_POS = 5'h0A  // Stored value at first power-up
)(
	input  wire logic  power_on,  // Supply stable
	input  wire logic  sel_n,     // Select pin
	input  wire logic  step_n,    // Step strobe pin
	input  wire logic  dir_up,    // Direction pin
	output logic [4:0] wiper,     // Tap position
	output logic [4:0] stored,    // Nonvolatile copy
	output logic [7:0] faults     // Host timing violations
);
	logic    active = 1'b0;
	realtime t_dir  = 0;
	realtime t_rise = 0;
	realtime t_sel  = 0;
	initial begin
		stored = INIT_POS;
		wiper = INIT_POS;
		faults = 8'h00;
	end
	always @(posedge power_on) begin
		wiper = stored;
		#PU_NS active = 1'b1;
	end
	always @(negedge power_on) active = 1'b0;
	always @(dir_up) t_dir = $realtime;
	always @(posedge step_n) t_rise = $realtime;
	always @(negedge sel_n) t_sel = $realtime;
	always @(negedge step_n) begin
		if (active && !sel_n) begin
			// Short setup would make a real part step the wrong way
			if ($realtime - t_dir < 100) faults = faults + 8'h01;
			if (dir_up && wiper != 5'h1F) wiper = wiper + 5'h01;
			else if (!dir_up && wiper != 5'h00) wiper = wiper - 5'h01;
		end
	end
	always @(posedge sel_n) begin
		if (active && step_n) begin
			if ($realtime - t_rise < 500) faults = faults + 8'h01;
			if ($realtime - t_sel < 100) faults = faults + 8'h01;
			active = 1'b0;
			#STORE_NS stored = wiper;
			active = 1'b1;
		end
	end
endmodule : pot_model

//--- sim/wiper_host_bench.sv
/*
 Self-checking bench for the wiper host against the potentiometer model.
 Assumes shortened power-up and store waits on both sides.
*/
`timescale 1ns/1ps
module wiper_host_bench;
	logic       clk           = 1'b0;
	logic       sys_rst       = 1'b1;
	logic       cmd_valid     = 1'b0;
	logic       cmd_store     = 1'b0;
	logic       cmd_save_only = 1'b0;
	logic [4:0] cmd_target    = 5'h00;
	logic       cmd_ready;
	logic       busy;
	logic [4:0] position;
	logic [4:0] stored_pos;
	logic       sel_n;
	logic       step_n;
	logic       dir_up;
	logic [4:0] wiper;
	logic [4:0] nv;
	logic [7:0] faults;
	int         errors        = 0;
	int         total_checks  = 0;

	always #5 clk = ~clk;

	wiper_host #(.PIN_ACT_CYC(20), .STORE_CYC(30)) u_dut (
		.CLK(clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD_TARGET(cmd_target), .CMD_STORE(cmd_store), .CMD_SAVE_ONLY(cmd_save_only),
		.KNOWN_POS(nv), .BUSY(busy), .POSITION(position), .STORED_POS(stored_pos),
		.SEL_N(sel_n), .STEP_N(step_n), .DIR_UP(dir_up));

	pot_model #(.PU_NS(200), .STORE_NS(300), .INIT_POS(5'h0A)) u_pot (
		.power_on(!sys_rst), .sel_n(sel_n), .step_n(step_n), .dir_up(dir_up),
		.wiper(wiper), .stored(nv), .faults(faults));

	task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// Sampled at the falling edge so comb outputs are settled
	task automatic wait_idle;
		int n;
		n = 0;
		@(negedge clk);
		while (busy !== 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("BUSY", 5'h00, {4'h0, busy});
	endtask : wait_idle

	task automatic run_cmd(input logic [4:0] tgt, input logic st, input logic so);
		@(posedge clk);
		cmd_target <= tgt;
		cmd_store <= st;
		cmd_save_only <= so;
		cmd_valid <= 1'b1;
		@(negedge clk);
		chk("CMD_READY", 5'h01, {4'h0, cmd_ready});
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_idle();
	endtask : run_cmd

	task automatic chk_state(input logic [4:0] pos, input logic [4:0] saved);
		chk("POSITION", pos, position);
		chk("wiper", pos, wiper);
		chk("STORED_POS", saved, stored_pos);
		chk("stored", saved, nv);
	endtask : chk_state

	task automatic power_up;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (10) @(negedge clk);
		chk("SEL_N early", 5'h01, {4'h0, sel_n});
		chk("CMD_READY early", 5'h00, {4'h0, cmd_ready});
		wait_idle();
	endtask : power_up

	task automatic t_boot;
		power_up();
		chk("POSITION", 5'h0A, position);
		chk("wiper", 5'h0A, wiper);
	endtask : t_boot

	task automatic t_up_store;
		run_cmd(5'h1F, 1'b1, 1'b0);
		chk_state(5'h1F, 5'h1F);
	endtask : t_up_store

	task automatic t_down_abort;
		run_cmd(5'h03, 1'b0, 1'b0);
		chk_state(5'h03, 5'h1F);
	endtask : t_down_abort

	task automatic t_noop;
		run_cmd(5'h03, 1'b0, 1'b0);
		chk_state(5'h03, 5'h1F);
	endtask : t_noop

	task automatic t_save_only;
		run_cmd(5'h1C, 1'b0, 1'b1);
		chk_state(5'h03, 5'h03);
	endtask : t_save_only

	task automatic t_same_target;
		run_cmd(5'h03, 1'b1, 1'b0);
		chk_state(5'h03, 5'h03);
	endtask : t_same_target

	task automatic t_lost_on_cycle;
		run_cmd(5'h14, 1'b0, 1'b0);
		chk_state(5'h14, 5'h03);
		power_up();
		chk("POSITION", 5'h03, position);
		chk("wiper", 5'h03, wiper);
	endtask : t_lost_on_cycle

	initial begin
		t_boot();
		t_up_store();
		t_down_abort();
		t_noop();
		t_save_only();
		t_same_target();
		t_lost_on_cycle();
		total_checks++;
		if (faults !== 8'h00) begin
			errors++;
			$display("MISMATCH faults expected 00 seen %h", faults);
		end
		finish_test();
	end

	// Whole run needs about 15 us
	initial begin
		#100000;
		errors++;
		finish_test();
	end
endmodule : wiper_host_bench
